// >>> dv/lds_host_model.sv
// Host model that drives the enable/PWM pin and the level dimming pin.
// Assumes callers enter its tasks just after a rising edge of ref_clk.
`timescale 1ns/1ps
module lds_host_model
  import lds_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Dimming pins
  output lds_pins_t pins
);
  initial
  begin
    pins = '0;
  end

  // Every pin change lands 2 ns after an edge, well clear of sampling
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #2;
    end
  endtask

  task automatic set_en(input logic v);
    pins.en = v;
  endtask

  task automatic set_level(input logic v);
    pins.level = v;
  endtask

  // Square cycles on the level pin, each ending low
  task automatic level_cycles(input int hi, input int per, input int n);
    int h;
    h = (hi < 5) ? 5 : hi; // Keeps each pulse at least 5 cycles, 100 ns, wide
    repeat (n)
    begin
      pins.level = 1'b1;
      tick(h);
      pins.level = 1'b0;
      tick(per - h);
    end
  endtask
endmodule

// >>> dv/tb_led_dimming_mode_sequencer.sv
// Self-checking bench for the dimming-mode sequencer core.
// Assumes lds_core and the host model; short wait parameters keep the run brief.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("mismatch %s expected %0d seen %0d", what, exp, got); \
    end \
  end
`define WAIT_FOR(what, cond, lim) \
  begin \
    wcnt = 0; \
    while ((cond) !== 1'b1 && wcnt < (lim)) \
    begin \
      host.tick(1); \
      wcnt++; \
    end \
    if ((cond) !== 1'b1) \
    begin \
      miscompares++; \
      $display("mismatch %s expected 1 seen 0", what); \
      wrap_up(); \
    end \
  end
module tb_led_dimming_mode_sequencer
  import lds_pkg::*;
;
  localparam int TB_POR = 20;
  localparam int TB_DISABLE = 300;
  localparam int TB_CONST = 200;

  logic ref_clk = 1'b0;
  logic reset;
  logic supply_lockout;
  logic spread_enable;
  logic [OFF_W-1:0] freq_set_pin;
  logic peak_trip;
  lds_pins_t pins;
  logic switch_on;
  logic off_timer_busy;
  lds_stat_t status;
  logic [CODE_W-1:0] vref_code;
  logic [CODE_W-1:0] vref_mv;
  int miscompares = 0;
  int num_checks = 0;
  int wcnt;
  int n;
  logic seen;

  always #10 ref_clk = ~ref_clk;

  lds_host_model host (
    .ref_clk(ref_clk),
    .pins(pins)
  );

  lds_core #(
    .P_POR_WAIT_CYC(TB_POR),
    .P_DIM_WAIT_CYC(10),
    .P_DISABLE_CYC(TB_DISABLE),
    .P_CONST_CYC(TB_CONST),
    .P_FIRST_CHG_CYC(512)
  ) uut (
    .ref_clk(ref_clk),
    .reset(reset),
    .supply_lockout(supply_lockout),
    .spread_enable(spread_enable),
    .freq_set_pin(freq_set_pin),
    .en_pwm_input(pins.en),
    .level_dim_input(pins.level),
    .peak_trip(peak_trip),
    .switch_on(switch_on),
    .off_timer_busy(off_timer_busy),
    .status(status),
    .vref_code(vref_code),
    .vref_mv(vref_mv)
  );

  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Lockout forces everything off; also used to reach idle between modes
  task automatic t_lock();
    host.set_en(1'b0);
    supply_lockout = 1'b1;
    host.tick(3);
    `CHECK("lock_status", 5'h00, status)
    `CHECK("lock_switch", 1'b0, switch_on)
    `CHECK("lock_vref", 8'h00, vref_code)
    supply_lockout = 1'b0;
    host.tick(4);
    `CHECK("idle_status", 5'h00, status)
  endtask

  // One peak trip; n returns the off counter length seen on busy
  task automatic peak_cycle();
    `WAIT_FOR("switch_up", switch_on, 10)
    peak_trip = 1'b1;
    host.tick(1);
    peak_trip = 1'b0;
    `WAIT_FOR("switch_down", switch_on === 1'b0, 3)
    n = 0;
    while (off_timer_busy === 1'b1 && n < 5000)
    begin
      host.tick(1);
      n++;
    end
    `CHECK("held_off", 1'b0, switch_on)
    host.tick(1);
    `CHECK("back_on", 1'b1, switch_on)
  endtask

  // Enable held high before lockout ends, then analog entry and level tracking
  task automatic t_early_analog();
    supply_lockout = 1'b0; // Enable stays high well past 5 us
    `WAIT_FOR("por_early", status.por_release, 4)
    host.tick(5);
    `CHECK("dim_early", 1'b0, status.dim_active)
    host.level_cycles(60, 100, 1); // First pulse over 1 us after startup
    `WAIT_FOR("dim_analog", status.dim_active, 10)
    `CHECK("mode_analog", MODE_ANALOG, status.mode)
    `CHECK("vref_start", 8'h00, vref_code)
    host.level_cycles(50, 100, 2);
    `CHECK("ramping", 1'b1, vref_code > 0 && vref_code < 127)
    host.level_cycles(50, 100, 4);
    `CHECK("vref_half", 8'd127, vref_code)
    `CHECK("mv_half", 8'd99, vref_mv)
    host.level_cycles(90, 100, 3);
    `CHECK("vref_90", 8'd229, vref_code)
    `CHECK("mv_90", 8'd179, vref_mv)
    host.tick(TB_CONST + 30);
    `CHECK("const_low", 8'hff, vref_code)
    `CHECK("mv_full", 8'd200, vref_mv)
    host.set_level(1'b1);
    host.tick(TB_CONST + 30);
    `CHECK("const_high", 8'h00, vref_code)
    `CHECK("gate_zero", 1'b0, switch_on)
    host.set_level(1'b0);
    host.tick(TB_CONST + 30);
    peak_cycle();
    `CHECK("off_len", 16, n)
  endtask

  task automatic t_disable();
    host.set_en(1'b0);
    host.tick(TB_DISABLE - 20);
    `CHECK("still_on", 1'b1, status.dim_active)
    `WAIT_FOR("disabled", status.dim_active === 1'b0, 40)
    `CHECK("mode_cleared", MODE_NONE, status.mode)
  endtask

  // From idle: enable pulse, startup waits, then mode choice
  task automatic enter_mode(input lds_mode_t m);
    // Flex starts low so its short level pulses never qualify as analog entry
    host.set_level(m == MODE_PWM);
    host.set_en(1'b1);
    n = 0;
    while (status.por_release !== 1'b1 && n < 40)
    begin
      host.tick(1);
      n++;
    end
    `CHECK("por_wait", 1'b1, n >= TB_POR && n <= TB_POR + 4)
    host.tick(260 - n); // Initial enable pulse just over 5 us
    `CHECK("no_mode_yet", 1'b0, status.dim_active)
    if (m == MODE_FLEX)
      host.level_cycles(10, 20, 2);
    host.set_en(1'b0); // Hybrid sees this fall with level low
    `WAIT_FOR("dim_on", status.dim_active, 6)
    `CHECK("mode", m, status.mode)
    host.set_en(1'b1);
    host.tick(2);
    if (m != MODE_FLEX)
      `CHECK("vref_full", 8'hff, vref_code)
  endtask

  task automatic t_pwm();
    `WAIT_FOR("pwm_on", switch_on, 6)
    host.set_en(1'b0);
    `WAIT_FOR("pwm_off", switch_on === 1'b0, 6)
    seen = 1'b0;
    repeat (20)
    begin
      host.tick(1);
      seen = seen | switch_on;
    end
    `CHECK("stays_off", 1'b0, seen)
    host.set_en(1'b1);
    repeat (8)
    begin
      host.tick(1);
      seen = seen | switch_on;
    end
    host.set_en(1'b0);
    host.tick(6);
    `CHECK("short_pulse", 1'b1, seen)
    host.set_en(1'b1);
  endtask

  // Dithered off time stays within seven percent and does move
  task automatic t_spread();
    spread_enable = 1'b1;
    freq_set_pin = 12'h064;
    seen = 1'b0;
    repeat (3)
    begin
      peak_cycle();
      `CHECK("dither_range", 1'b1, n >= 93 && n <= 107)
      seen = seen | (n != 100);
      host.tick(3000);
    end
    `CHECK("dither_moves", 1'b1, seen)
  endtask

  // Off time reaches the full count and never collapses to zero
  task automatic t_off_len();
    spread_enable = 1'b0;
    freq_set_pin = 12'hfff;
    host.tick(2);
    peak_cycle();
    `CHECK("off_max", 4095, n)
    freq_set_pin = 12'h000;
    host.tick(2);
    peak_cycle();
    `CHECK("off_min", 1, n)
  endtask

  initial
  begin
    reset = 1'b1;
    supply_lockout = 1'b1;
    spread_enable = 1'b0;
    freq_set_pin = 12'h010;
    peak_trip = 1'b0;
    host.tick(16);
    reset = 1'b0;
    host.set_en(1'b1);
    host.tick(20);
    `CHECK("locked_status", 5'h00, status)
    `CHECK("locked_switch", 1'b0, switch_on)
    t_early_analog();
    t_disable();
    enter_mode(MODE_PWM);
    t_pwm();
    t_spread();
    t_off_len();
    t_lock();
    enter_mode(MODE_FLEX);
    t_lock();
    enter_mode(MODE_HYBRID);
    wrap_up();
  end
endmodule

// >>> logic/lds_core.sv
// Enable sequencing, dimming-mode decode, duty-to-reference and off-time
// control for a buck LED driver. Assumes pins and the lockout indication are
// synchronous logic levels and peak_trip comes from the analog comparator.
// What this block does
// R1: Peak trip ends on-time, starts off-time counter
// R2: Optional off-time dither, seven percent, 2 kHz
// R3: Lockout keeps everything off and idle
// R4: Early enable: release reset now, 100 us
// R5: Host holds early enable over 5 us
// R6: Host waits about 1 ms before dimming
// R7: Late enable: 200 us, release, 100 us
// R8: Re-enable without lockout waits 300 us total
// R9: Host enables with a pulse over 5 us
// R10: Enable low about 57 ms disables device
// R11: Mode picked from both pins at start
// R12: Dimming starts after the startup waits
// R13: Host enters hybrid via enable fall, level low
// R14: PWM mode: switching follows enable level
// R15: Enable pulses of 150 ns still honoured
// R16: Analog needs first pulse of 1 us
// R17: Reference set after second level cycle ends
// R18: Host keeps later pulses over 100 ns
// R19: Reference linear in duty, 200 mV full
// R20: Constant level detected in 15 ms
// R21: First reference change ramps over 5 ms
// R22: Duty resolved to eight bits
// R23: Later duty changes applied within microseconds
// R24: Pins synchronised, duty counted in clock cycles
// R25: Mode latched until disable or lockout
`timescale 1ns/1ps
module lds_core
  import lds_pkg::*;
#(
  parameter int P_POR_WAIT_CYC = POR_WAIT_CYC,
  parameter int P_DIM_WAIT_CYC = DIM_WAIT_CYC,
  parameter int P_DISABLE_CYC = DISABLE_CYC,
  parameter int P_CONST_CYC = CONST_CYC,
  parameter int P_FIRST_CHG_CYC = FIRST_CHG_CYC
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Supply and configuration
  input wire logic supply_lockout,
  input wire logic spread_enable,
  input wire logic [OFF_W-1:0] freq_set_pin,
  // Dimming pins
  input wire logic en_pwm_input,
  input wire logic level_dim_input,
  // Power stage
  input wire logic peak_trip,
  output logic switch_on,
  output logic off_timer_busy,
  // Status and reference
  output lds_stat_t status,
  output logic [CODE_W-1:0] vref_code,
  output logic [CODE_W-1:0] vref_mv
);
  localparam int STEP_CYC = P_FIRST_CHG_CYC / (CODE_FS + 1);
  localparam logic [7:0] FP_CYC = 8'(FIRST_PULSE_CYC);
  localparam logic [PCT_W-1:0] PCT_MID = PCT_W'(SS_CENTER_PCT);
  localparam logic [PCT_W-1:0] PCT_HI = PCT_W'(SS_CENTER_PCT + SS_DEV_PCT);
  localparam logic [PCT_W-1:0] PCT_LO = PCT_W'(SS_CENTER_PCT - SS_DEV_PCT);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Two-stage synchronisers, then a delayed copy for edge detection
  lds_pins_t pin_s1_ff, pin_s2_ff, pin_d_ff;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_d_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= '{en: en_pwm_input, level: level_dim_input}; // see R24
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff <= pin_s2_ff;
    end
  end
  wire logic en_lvl = pin_s2_ff.en;
  wire logic lv_lvl = pin_s2_ff.level;
  wire logic en_fall = !pin_s2_ff.en && pin_d_ff.en;
  wire logic lv_rise = pin_s2_ff.level && !pin_d_ff.level;
  wire logic lv_fall = !pin_s2_ff.level && pin_d_ff.level;

  // Startup sequencer
  lds_seq_t state_ff, nxt_state;
  lds_mode_t mode_ff, nxt_mode, sel_mode;
  lds_stat_t stat_ff, nxt_stat;
  logic [CNT_W-1:0] tmr_ff, nxt_tmr, low_cnt_ff, nxt_low_cnt;
  logic en_fell_ff, lv_edge_ff, lv_qual_ff;
  logic [7:0] lv_hi_ff;
  logic [CODE_W-1:0] vref_ff;
  wire logic disable_hit = (low_cnt_ff == CNT_W'(P_DISABLE_CYC - 1));
  wire logic abort = supply_lockout || disable_hit;
  wire logic por_end = (tmr_ff == CNT_W'(P_POR_WAIT_CYC - 1));
  wire logic dim_end = (tmr_ff == CNT_W'(P_DIM_WAIT_CYC - 1));
  wire logic in_sel = (state_ff == SEQ_DIM_WAIT) || (state_ff == SEQ_SELECT);
  wire logic en_ev = en_fall || en_fell_ff;
  wire logic lv_ev = lv_rise || lv_fall || lv_edge_ff;
  wire logic lv_qual_now = lv_fall && (lv_hi_ff >= FP_CYC);

  // Enable low time; cleared by any high level, held at the limit
  assign nxt_low_cnt = (en_lvl || state_ff == SEQ_LOCK) ? '0 :
                       (disable_hit ? low_cnt_ff : low_cnt_ff + CNT_W'(1)); // see R10

  always_comb
  begin
    sel_mode = MODE_NONE;
    if (en_ev)
      sel_mode = lv_ev ? MODE_FLEX : (lv_lvl ? MODE_PWM : MODE_HYBRID); // see R11
    else if (lv_qual_ff || lv_qual_now)
      sel_mode = MODE_ANALOG; // see R16
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_LOCK:
        if (!supply_lockout)
          nxt_state = en_lvl ? SEQ_DIM_WAIT : SEQ_IDLE; // see R4
      SEQ_IDLE:
        if (en_lvl)
          nxt_state = SEQ_POR_WAIT; // see R7
      SEQ_POR_WAIT:
        if (por_end)
          nxt_state = SEQ_DIM_WAIT; // see R8
      SEQ_DIM_WAIT:
        if (dim_end)
          nxt_state = SEQ_SELECT; // see R12
      SEQ_SELECT:
        if (sel_mode != MODE_NONE)
          nxt_state = SEQ_RUN;
      SEQ_RUN:
        nxt_state = SEQ_RUN;
      default:
        nxt_state = SEQ_LOCK;
    endcase
    if (disable_hit && state_ff != SEQ_LOCK && state_ff != SEQ_IDLE)
      nxt_state = SEQ_IDLE; // see R10
    if (supply_lockout)
      nxt_state = SEQ_LOCK; // see R3
  end

  wire logic timing = (state_ff == SEQ_POR_WAIT) || (state_ff == SEQ_DIM_WAIT);
  assign nxt_tmr = (nxt_state != state_ff || !timing) ? '0 : tmr_ff + CNT_W'(1);
  // Mode is only loaded on entry to run and dropped on any exit
  assign nxt_mode = (state_ff == SEQ_SELECT && nxt_state == SEQ_RUN) ? sel_mode :
                    ((state_ff == SEQ_RUN && nxt_state == SEQ_RUN) ? mode_ff : MODE_NONE); // see R25
  assign nxt_stat = '{por_release: (nxt_state == SEQ_DIM_WAIT || nxt_state == SEQ_SELECT ||
                                    nxt_state == SEQ_RUN),
                      dim_active: (nxt_state == SEQ_RUN),
                      mode: nxt_mode};

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= SEQ_LOCK;
      tmr_ff <= '0;
      low_cnt_ff <= '0;
      mode_ff <= MODE_NONE;
      stat_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      low_cnt_ff <= nxt_low_cnt;
      mode_ff <= nxt_mode;
      stat_ff <= nxt_stat;
    end
  end

  // Pin activity seen during the dimming wait and the selection window
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      en_fell_ff <= 1'b0;
      lv_edge_ff <= 1'b0;
      lv_qual_ff <= 1'b0;
      lv_hi_ff <= '0;
    end
    else if (!in_sel)
    begin
      en_fell_ff <= 1'b0;
      lv_edge_ff <= 1'b0;
      lv_qual_ff <= 1'b0;
      lv_hi_ff <= '0;
    end
    else
    begin
      en_fell_ff <= en_ev;
      lv_edge_ff <= lv_ev;
      lv_qual_ff <= lv_qual_ff || lv_qual_now; // see R16
      if (lv_rise)
        lv_hi_ff <= 8'h01;
      else if (lv_lvl && lv_hi_ff != 8'hff)
        lv_hi_ff <= lv_hi_ff + 8'h01;
    end
  end

  // Duty measurement on the level dimming input
  logic [CNT_W-1:0] per_cnt_ff, hi_cnt_ff, step_ff;
  logic [1:0] rise_cnt_ff;
  logic [CODE_W-1:0] tgt_ff;
  logic tgt_vld_ff, first_chg_ff;
  wire logic dim_meas = (state_ff == SEQ_RUN) &&
                        (mode_ff == MODE_ANALOG || mode_ff == MODE_FLEX);
  wire logic const_hit = (per_cnt_ff == CNT_W'(P_CONST_CYC - 1));
  // High time times full code, divided by period: eight-bit duty code
  wire logic [CNT_W+7:0] hi_scaled = {hi_cnt_ff, 8'h00} - {8'h00, hi_cnt_ff};
  wire logic [CNT_W+7:0] duty_q = (per_cnt_ff == '0) ? '0 : hi_scaled / {8'h00, per_cnt_ff};
  wire logic [CODE_W-1:0] duty8 = (duty_q > (CNT_W+8)'(CODE_FS)) ?
                                  CODE_W'(CODE_FS) : duty_q[CODE_W-1:0]; // see R22

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      per_cnt_ff <= '0;
      hi_cnt_ff <= '0;
      rise_cnt_ff <= '0;
      tgt_ff <= '0;
      tgt_vld_ff <= 1'b0;
    end
    else if (!dim_meas)
    begin
      per_cnt_ff <= '0;
      hi_cnt_ff <= '0;
      rise_cnt_ff <= '0;
      tgt_ff <= '0;
      tgt_vld_ff <= 1'b0;
    end
    else if (lv_rise)
    begin
      per_cnt_ff <= CNT_W'(1); // see R24
      hi_cnt_ff <= CNT_W'(1);
      if (rise_cnt_ff != 2'h2)
        rise_cnt_ff <= rise_cnt_ff + 2'h1;
      if (rise_cnt_ff != 2'h0)
      begin
        tgt_ff <= duty8; // see R17
        tgt_vld_ff <= 1'b1;
      end
    end
    else if (const_hit)
    begin
      // Steady low means full duty, steady high means none
      tgt_ff <= lv_lvl ? '0 : CODE_W'(CODE_FS); // see R20
      tgt_vld_ff <= 1'b1;
      per_cnt_ff <= '0;
      hi_cnt_ff <= '0;
    end
    else
    begin
      per_cnt_ff <= per_cnt_ff + CNT_W'(1);
      if (lv_lvl)
        hi_cnt_ff <= hi_cnt_ff + CNT_W'(1);
    end
  end

  // Reference: slow ramp for the first change, direct moves afterwards
  wire logic step_end = (step_ff == CNT_W'(STEP_CYC - 1));
  wire logic [15:0] mv_prod = {8'h00, vref_ff} * 16'(VREF_FS_MV);
  wire logic [15:0] mv_q = mv_prod / 16'(CODE_FS);
  logic [CODE_W-1:0] mv_ff;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      vref_ff <= '0;
      first_chg_ff <= 1'b1;
      step_ff <= '0;
      mv_ff <= '0;
    end
    else
    begin
      mv_ff <= mv_q[CODE_W-1:0]; // see R19
      if (state_ff != SEQ_RUN)
      begin
        vref_ff <= '0;
        first_chg_ff <= 1'b1;
        step_ff <= '0;
      end
      else if (!dim_meas)
        vref_ff <= CODE_W'(CODE_FS);
      else if (!tgt_vld_ff)
        step_ff <= '0;
      else if (first_chg_ff)
      begin
        if (vref_ff == tgt_ff)
          first_chg_ff <= 1'b0;
        else if (step_end)
        begin
          step_ff <= '0;
          vref_ff <= (vref_ff < tgt_ff) ? vref_ff + 8'h01 : vref_ff - 8'h01; // see R21
        end
        else
          step_ff <= step_ff + CNT_W'(1);
      end
      else
        vref_ff <= tgt_ff; // see R23
    end
  end

  // Spread spectrum triangle between low and high percent
  logic [PCT_W-1:0] ss_pct_ff;
  logic ss_up_ff;
  logic [SS_TMR_W-1:0] ss_tmr_ff;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ss_pct_ff <= PCT_MID;
      ss_up_ff <= 1'b1;
      ss_tmr_ff <= '0;
    end
    else if (!spread_enable)
    begin
      ss_pct_ff <= PCT_MID;
      ss_up_ff <= 1'b1;
      ss_tmr_ff <= '0;
    end
    else if (ss_tmr_ff == SS_TMR_W'(SS_STEP_CYC - 1))
    begin
      ss_tmr_ff <= '0;
      ss_pct_ff <= ss_up_ff ? ss_pct_ff + 7'h01 : ss_pct_ff - 7'h01; // see R2
      if (ss_up_ff && ss_pct_ff == PCT_HI - 7'h01)
        ss_up_ff <= 1'b0;
      else if (!ss_up_ff && ss_pct_ff == PCT_LO + 7'h01)
        ss_up_ff <= 1'b1;
    end
    else
      ss_tmr_ff <= ss_tmr_ff + SS_TMR_W'(1);
  end

  // Off-time length; clamped so dithering never wraps the counter
  wire logic [OFF_W+PCT_W-1:0] off_prod = {{PCT_W{1'b0}}, freq_set_pin} *
                                          {{OFF_W{1'b0}}, ss_pct_ff};
  wire logic [OFF_W+PCT_W-1:0] off_q = off_prod / (OFF_W+PCT_W)'(SS_CENTER_PCT);
  wire logic [OFF_W-1:0] off_len = (off_q > (OFF_W+PCT_W)'({OFF_W{1'b1}})) ? {OFF_W{1'b1}} :
                                   ((off_q == '0) ? OFF_W'(1) : off_q[OFF_W-1:0]);

  // Switch control
  logic sw_on_ff, nxt_sw;
  logic [OFF_W-1:0] off_cnt_ff, nxt_off;
  wire logic off_busy = (off_cnt_ff != '0);
  // Outside analog mode any enable pulse that survives the synchroniser gates the switch, see R15
  wire logic pin_gate = (mode_ff == MODE_ANALOG) ? (vref_ff != '0) : en_lvl; // see R14
  wire logic gate = !supply_lockout && (state_ff == SEQ_RUN) && pin_gate; // see R3
  always_comb
  begin
    nxt_off = off_busy ? off_cnt_ff - OFF_W'(1) : '0;
    nxt_sw = sw_on_ff;
    if (sw_on_ff && peak_trip)
    begin
      nxt_sw = 1'b0; // see R1
      nxt_off = off_len;
    end
    else if (!gate)
      nxt_sw = 1'b0;
    else if (!sw_on_ff && !off_busy)
      nxt_sw = 1'b1;
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sw_on_ff <= 1'b0;
      off_cnt_ff <= '0;
    end
    else
    begin
      sw_on_ff <= nxt_sw;
      off_cnt_ff <= nxt_off;
    end
  end

  assign switch_on = sw_on_ff;
  assign off_timer_busy = off_busy;
  assign status = stat_ff;
  assign vref_code = vref_ff;
  assign vref_mv = mv_ff;

  sequence s_por_end;
    state_ff == SEQ_POR_WAIT && por_end && !abort;
  endsequence
  sequence s_dim_end;
    state_ff == SEQ_DIM_WAIT && dim_end && !abort;
  endsequence

  AST_PEAK_OFF: assert property (sw_on_ff && peak_trip // see R1
    |=> !sw_on_ff && off_cnt_ff == $past(off_len))
    else $error("switch not cut on peak trip");
  AST_OFF_HOLD: assert property (off_busy && !sw_on_ff |=> !sw_on_ff) // see R1
    else $error("switch on during off time");
  AST_LOCK_QUIET: assert property (supply_lockout |=> !sw_on_ff && state_ff == SEQ_LOCK) // see R3
    else $error("activity during lockout");
  AST_EARLY_POR: assert property (state_ff == SEQ_LOCK && !supply_lockout && en_lvl // see R4
    |=> status.por_release && state_ff == SEQ_DIM_WAIT)
    else $error("early enable did not release reset");
  AST_LATE_POR: assert property (state_ff == SEQ_POR_WAIT |-> !status.por_release) // see R7
    else $error("reset released during wait");
  AST_POR_DONE: assert property (s_por_end |=> state_ff == SEQ_DIM_WAIT && status.por_release) // see R8
    else $error("wait did not end in release");
  AST_DIM_START: assert property (s_dim_end |=> state_ff == SEQ_SELECT ##1 1'b1) // see R12
    else $error("dimming start late");
  AST_DISABLE: assert property (disable_hit && !supply_lockout && state_ff != SEQ_LOCK // see R10
    && state_ff != SEQ_IDLE |=> state_ff == SEQ_IDLE && !status.dim_active)
    else $error("long low did not disable");
  AST_PWM_GATE: assert property (state_ff == SEQ_RUN && mode_ff == MODE_PWM && !en_lvl // see R14
    && !supply_lockout |=> !sw_on_ff)
    else $error("switch on while enable low");
  AST_MODE_HOLD: assert property (state_ff == SEQ_RUN ##1 state_ff == SEQ_RUN |-> $stable(mode_ff)) // see R25
    else $error("mode changed while running");
  AST_SS_BAND: assert property (ss_pct_ff >= PCT_LO && ss_pct_ff <= PCT_HI) // see R2
    else $error("dither out of band");
  AST_REF_LOAD: assert property (dim_meas && lv_rise && rise_cnt_ff != 2'h0 // see R17
    |=> tgt_vld_ff && tgt_ff == $past(duty8))
    else $error("duty not loaded at cycle end");
endmodule

// >>> logic/lds_pkg.sv
// Constants and types shared by the dimming-mode sequencer.
// Assumes a single 50 MHz reference clock; all cycle counts derive from it.
package lds_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // Startup sequencing
  localparam int T_POR_WAIT_US = 200;
  localparam int POR_WAIT_CYC = T_POR_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int T_DIM_WAIT_US = 100;
  localparam int DIM_WAIT_CYC = T_DIM_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int T_DISABLE_MS = 57;
  localparam int DISABLE_CYC = T_DISABLE_MS * 1000000 / CLK_PERIOD_NS;
  // Level dimming input timing
  localparam int T_FIRST_PULSE_NS = 1000;
  localparam int FIRST_PULSE_CYC = (T_FIRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_CONST_MS = 15;
  localparam int CONST_CYC = T_CONST_MS * 1000000 / CLK_PERIOD_NS;
  localparam int T_FIRST_CHG_MS = 5;
  localparam int FIRST_CHG_CYC = T_FIRST_CHG_MS * 1000000 / CLK_PERIOD_NS;
  // Spread spectrum: triangle of percent scale on the off time
  localparam int SS_MOD_HZ = 2000;
  localparam int SS_DEV_PCT = 7;
  localparam int SS_CENTER_PCT = 100;
  localparam int SS_STEP_CYC = 1000000000 / SS_MOD_HZ / CLK_PERIOD_NS / (4 * SS_DEV_PCT);
  // Reference scaling and register widths
  localparam int VREF_FS_MV = 200;
  localparam int CODE_W = 8;
  localparam int CODE_FS = 255;
  localparam int CNT_W = 22;
  localparam int OFF_W = 12;
  localparam int PCT_W = 7;
  localparam int SS_TMR_W = 10;

  typedef enum logic [2:0] {
    SEQ_LOCK,
    SEQ_IDLE,
    SEQ_POR_WAIT,
    SEQ_DIM_WAIT,
    SEQ_SELECT,
    SEQ_RUN
  } lds_seq_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_PWM,
    MODE_ANALOG,
    MODE_HYBRID,
    MODE_FLEX
  } lds_mode_t;

  typedef struct packed {
    logic en;
    logic level;
  } lds_pins_t;

  typedef struct packed {
    logic por_release;
    logic dim_active;
    lds_mode_t mode;
  } lds_stat_t;
endpackage
